//--- core/ipwu_cfg.svh
// Constants of the interrupt priority and wake unit
`ifndef IPWU_CFG_SVH
`define IPWU_CFG_SVH

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define IPWU_NUM_SRC 59
`define IPWU_NUM_VEC 16
`define IPWU_NUM_EXC 5

// ---------------------------------------------------------------
// Vector addresses and stack usage
// ---------------------------------------------------------------
`define IPWU_VEC_BASE 20'h08000
`define IPWU_EXC_VEC 20'h08080
`define IPWU_CTX_BYTES 3'h6

// ---------------------------------------------------------------
// First source index of each vector slot (slot 4 and 10 empty)
// ---------------------------------------------------------------
`define IPWU_S_WDT 0
`define IPWU_S_BT 1
`define IPWU_S_T0 3
`define IPWU_S_V3 5
`define IPWU_S_V5 6
`define IPWU_S_V6 7
`define IPWU_S_V7 14
`define IPWU_S_V8 21
`define IPWU_S_V9 24
`define IPWU_S_V11 28
`define IPWU_S_V12 31
`define IPWU_S_V13 33
`define IPWU_S_V14 39
`define IPWU_S_V15 47
`define IPWU_S_END 59

// ---------------------------------------------------------------
// Wake-capable source ranges
// ---------------------------------------------------------------
`define IPWU_W_ASYNC2_LO 10
`define IPWU_W_ASYNC2_HI 13
`define IPWU_W_SYNCB_LO 26
`define IPWU_W_SYNCB_HI 27
`define IPWU_W_ASYNC3_LO 35
`define IPWU_W_ASYNC3_HI 38
`define IPWU_W_SYNCA_LO 41
`define IPWU_W_ASYNCA4_HI 46
`define IPWU_W_PORTS_LO 47
`define IPWU_W_PORTS_HI 57
`define IPWU_W_BT_LO 1
`define IPWU_W_BT_HI 2

// ---------------------------------------------------------------
// Level codes
// ---------------------------------------------------------------
`define IPWU_LVL_MAX 2'h2

`endif

//--- core/ipwu_pkg.sv
// Types of the interrupt priority and wake unit
package ipwu_pkg;

  // Standby state, one-hot
  typedef enum logic [3:0] {
    IPWU_RUN = 4'h1,
    IPWU_HALT = 4'h2,
    IPWU_HOLD = 4'h4,
    IPWU_LOW_SPEED_HOLD_STANDBY = 4'h8
  } ipwu_stby_t;

  // Two-bit priority level of one vector
  typedef logic [1:0] ipwu_lvl_t;

  // Rank: 0 idle, 1..3 levels, used for nesting compare
  typedef logic [1:0] ipwu_rank_t;

endpackage

//--- core/ipwu_arb_if.sv
// Carrier between the controller and its priority selector
`timescale 1ns/100ps
`default_nettype none

interface ipwu_arb_if;
  logic [15:0] vec_req;
  logic [31:0] vec_lvl;
  logic [1:0] cur_rank;
  logic per_allow;
  logic exc_req;
  logic grant;
  logic grant_exc;
  logic [3:0] grant_idx;
  logic [1:0] grant_rank;

  modport ctrl (output vec_req, vec_lvl, cur_rank, per_allow, exc_req,
                input grant, grant_exc, grant_idx, grant_rank);
  modport arb (input vec_req, vec_lvl, cur_rank, per_allow, exc_req,
               output grant, grant_exc, grant_idx, grant_rank);
endinterface

`default_nettype wire

//--- core/ipwu_arbiter.sv
// Priority selector for peripheral vectors and the exception vector
`timescale 1ns/100ps
`default_nettype none
`include "ipwu_cfg.svh"

module ipwu_arbiter (
  ipwu_arb_if.arb a // Requests in, grant out
);

  // ---------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------
  logic [1:0] best_rank;
  logic [3:0] best_idx;

  // Clamp code 3 onto the top level, then rank 1..3
  function automatic logic [1:0] rank_of(input logic [1:0] code);
    rank_of = ((code > `IPWU_LVL_MAX) ? `IPWU_LVL_MAX : code) + 2'h1;
  endfunction

  // Ascending scan, strict compare keeps the lowest address on ties
  always_comb
  begin
    best_rank = 2'h0;
    best_idx = 4'h0;
    for (int v = 0; v < `IPWU_NUM_VEC; v++)
    begin
      if (a.vec_req[v] && (rank_of(a.vec_lvl[2*v +: 2]) > best_rank))
      begin
        best_rank = rank_of(a.vec_lvl[2*v +: 2]);
        best_idx = v[3:0];
      end
    end
  end

  // Exception wins over any peripheral; peripheral must beat current level
  always_comb
  begin
    a.grant_exc = a.exc_req;
    a.grant_idx = best_idx;
    a.grant_rank = best_rank;
    a.grant = a.exc_req || (a.per_allow && (best_rank > a.cur_rank));
  end

endmodule // ipwu_arbiter

`default_nettype wire

//--- core/ipwu_top.sv
// Interrupt controller with nesting, exception class and standby wake
`timescale 1ns/100ps
`default_nettype none
`include "ipwu_cfg.svh"

module ipwu_top (
  input wire logic clock, // System clock, 40 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [58:0] src_req, // Peripheral source event pulses
  input wire logic [58:0] src_enable, // Per-source enables
  input wire logic [58:0] src_clear, // Software clear of pending flags
  input wire logic [31:0] vec_level, // Two-bit level per vector slot
  input wire logic global_irq_en, // Global enable, peripherals only
  input wire logic [4:0] exc_req, // Exception source event pulses
  input wire logic [4:0] exc_clear, // Software clear of exception flags
  input wire logic [7:0] exception_enable_low, // Exception source enables
  input wire logic [7:0] exception_enable_high, // Bit 0: exception class enable
  input wire logic wdt_expire, // Watchdog expiry pulse
  input wire logic wdt_reset_mode, // 1: expiry resets, 0: interrupts
  input wire logic irq_ack, // Core takes the offered vector
  input wire logic irq_return, // Core finished the current handler
  input wire logic halt_enter, // Enter halt standby
  input wire logic hold_enter, // Enter full hold standby
  input wire logic low_speed_hold_standby_enter, // Enter low-speed hold
  input wire logic reset_pin_low, // Reset pin at low level
  input wire logic [7:0] ext_pin_level_hit, // External pins at set level
  output logic irq_req, // Vector offered to the core
  output logic [19:0] irq_vector, // Offered vector address
  output logic irq_is_exc, // Offered vector is the exception one
  output logic ctx_push, // Pulse: push context on stack
  output logic [2:0] ctx_push_bytes, // Bytes pushed with the context
  output logic ctx_save_psw, // Status word saved with context
  output logic wdt_reset, // Pulse: watchdog reset request
  output logic [58:0] src_pending, // Pending source flags
  output logic [4:0] exc_pending, // Pending exception flags
  output logic [2:0] level_active, // Nesting levels in service
  output logic exc_active, // Exception handler running
  output logic stby_halt, // Halt standby active
  output logic stby_hold, // Full hold standby active
  output logic stby_low_speed_hold // Low-speed hold standby active
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Vector slot of a source index
  function automatic logic [3:0] src_vec(input int i);
    if (i < `IPWU_S_BT) src_vec = 4'h0;
    else if (i < `IPWU_S_T0) src_vec = 4'h1;
    else if (i < `IPWU_S_V3) src_vec = 4'h2;
    else if (i < `IPWU_S_V5) src_vec = 4'h3;
    else if (i < `IPWU_S_V6) src_vec = 4'h5;
    else if (i < `IPWU_S_V7) src_vec = 4'h6;
    else if (i < `IPWU_S_V8) src_vec = 4'h7;
    else if (i < `IPWU_S_V9) src_vec = 4'h8;
    else if (i < `IPWU_S_V11) src_vec = 4'h9;
    else if (i < `IPWU_S_V12) src_vec = 4'hb;
    else if (i < `IPWU_S_V13) src_vec = 4'hc;
    else if (i < `IPWU_S_V14) src_vec = 4'hd;
    else if (i < `IPWU_S_V15) src_vec = 4'he;
    else src_vec = 4'hf;
  endfunction

  // Full hold wake-capable source
  function automatic logic hold_wake_src(input int i);
    hold_wake_src = (i >= `IPWU_W_ASYNC2_LO && i <= `IPWU_W_ASYNC2_HI) ||
                    (i >= `IPWU_W_SYNCB_LO && i <= `IPWU_W_SYNCB_HI) ||
                    (i >= `IPWU_W_ASYNC3_LO && i <= `IPWU_W_ASYNC3_HI) ||
                    (i >= `IPWU_W_SYNCA_LO && i <= `IPWU_W_ASYNCA4_HI) ||
                    (i >= `IPWU_W_PORTS_LO && i <= `IPWU_W_PORTS_HI);
  endfunction

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  ipwu_arb_if arb_bus ();
  ipwu_pkg::ipwu_stby_t stby_reg;
  ipwu_pkg::ipwu_stby_t stby_next;
  logic [58:0] pend_reg;
  logic [58:0] set_vec;
  logic [4:0] exc_pend_reg;
  logic [58:0] live;
  logic [15:0] vec_req_w;
  logic exc_live;
  logic [2:0] lvl_act_reg;
  logic exc_act_reg;
  logic req_reg;
  logic exc_off_reg;
  logic [1:0] rank_off_reg;
  logic [19:0] vec_off_reg;
  logic take;
  logic hold_wake;
  logic low_speed_hold_standby_wake;

  // ---------------------------------------------------------------
  // Pending flags
  // ---------------------------------------------------------------

  // Watchdog expiry joins the first source unless reset mode
  always_comb
  begin
    set_vec = src_req;
    set_vec[`IPWU_S_WDT] = src_req[`IPWU_S_WDT] || (wdt_expire && !wdt_reset_mode);
  end

  // Sticky flags, set beats clear, held until cleared
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      pend_reg <= 59'h0;
    else
      pend_reg <= set_vec | (pend_reg & ~src_clear);
  end

  // Exception flags, same policy
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      exc_pend_reg <= 5'h0;
    else
      exc_pend_reg <= exc_req | (exc_pend_reg & ~exc_clear);
  end

  // Watchdog reset pulse
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      wdt_reset <= 1'b0;
    else
      wdt_reset <= wdt_expire && wdt_reset_mode;
  end

  // ---------------------------------------------------------------
  // Vector gathering
  // ---------------------------------------------------------------

  // OR enabled pending sources onto their shared vector
  always_comb
  begin
    live = pend_reg & src_enable;
    vec_req_w = 16'h0;
    for (int i = 0; i < `IPWU_S_END; i++)
      vec_req_w[src_vec(i)] = vec_req_w[src_vec(i)] | live[i];
  end

  // Exception class gated by its own enables only
  assign exc_live = exception_enable_high[0] &&
                    (|(exc_pend_reg & exception_enable_low[4:0]));

  // Arbiter inputs
  always_comb
  begin
    arb_bus.vec_req = vec_req_w;
    arb_bus.vec_lvl = vec_level;
    arb_bus.cur_rank = lvl_act_reg[2] ? 2'h3 : (lvl_act_reg[1] ? 2'h2 : (lvl_act_reg[0] ? 2'h1 : 2'h0));
    arb_bus.per_allow = global_irq_en && !exc_act_reg;
    arb_bus.exc_req = exc_live && !exc_act_reg;
  end

  ipwu_arbiter u_arb (
    .a (arb_bus)
  );

  // ---------------------------------------------------------------
  // Offer to the core
  // ---------------------------------------------------------------
  assign take = req_reg && irq_ack;

  // Registered offer, withdrawn in the cycle it is taken
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      req_reg <= 1'b0;
      exc_off_reg <= 1'b0;
      rank_off_reg <= 2'h0;
      vec_off_reg <= 20'h0;
    end
    else
    begin
      req_reg <= arb_bus.grant && !take && !irq_return;
      exc_off_reg <= arb_bus.grant_exc;
      rank_off_reg <= arb_bus.grant_rank;
      vec_off_reg <= arb_bus.grant_exc ? `IPWU_EXC_VEC :
                     (`IPWU_VEC_BASE + {14'h0, arb_bus.grant_idx, 2'h0});
    end
  end

  // Nesting record, exception handler first to return
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      lvl_act_reg <= 3'h0;
      exc_act_reg <= 1'b0;
    end
    else if (take)
    begin
      if (exc_off_reg)
        exc_act_reg <= 1'b1;
      else
        lvl_act_reg[rank_off_reg - 2'h1] <= 1'b1;
    end
    else if (irq_return)
    begin
      if (exc_act_reg)
        exc_act_reg <= 1'b0;
      else if (lvl_act_reg[2])
        lvl_act_reg[2] <= 1'b0;
      else if (lvl_act_reg[1])
        lvl_act_reg[1] <= 1'b0;
      else
        lvl_act_reg[0] <= 1'b0;
    end
  end

  // Context push on vector entry
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ctx_push <= 1'b0;
    else
      ctx_push <= take;
  end

  // ---------------------------------------------------------------
  // Standby control
  // ---------------------------------------------------------------

  // Full hold and low-speed hold wake causes
  always_comb
  begin
    hold_wake = reset_pin_low || (|ext_pin_level_hit);
    low_speed_hold_standby_wake = 1'b0;
    for (int i = 0; i < `IPWU_S_END; i++)
    begin
      if (hold_wake_src(i))
        hold_wake = hold_wake | pend_reg[i];
      if (i >= `IPWU_W_BT_LO && i <= `IPWU_W_BT_HI)
        low_speed_hold_standby_wake = low_speed_hold_standby_wake | pend_reg[i];
    end
    low_speed_hold_standby_wake = low_speed_hold_standby_wake | hold_wake;
  end

  // Standby state transitions
  always_comb
  begin
    case (stby_reg)
      ipwu_pkg::IPWU_RUN:
        if (halt_enter)
          stby_next = ipwu_pkg::IPWU_HALT;
        else if (hold_enter)
          stby_next = ipwu_pkg::IPWU_HOLD;
        else if (low_speed_hold_standby_enter)
          stby_next = ipwu_pkg::IPWU_LOW_SPEED_HOLD_STANDBY;
        else
          stby_next = ipwu_pkg::IPWU_RUN;
      ipwu_pkg::IPWU_HALT:
        stby_next = (reset_pin_low || arb_bus.grant) ? ipwu_pkg::IPWU_RUN : ipwu_pkg::IPWU_HALT;
      ipwu_pkg::IPWU_HOLD:
        stby_next = hold_wake ? ipwu_pkg::IPWU_RUN : ipwu_pkg::IPWU_HOLD;
      ipwu_pkg::IPWU_LOW_SPEED_HOLD_STANDBY:
        stby_next = low_speed_hold_standby_wake ? ipwu_pkg::IPWU_RUN : ipwu_pkg::IPWU_LOW_SPEED_HOLD_STANDBY;
      default:
        stby_next = ipwu_pkg::IPWU_RUN;
    endcase
  end

  // Standby state register
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      stby_reg <= ipwu_pkg::IPWU_RUN;
    else
      stby_reg <= stby_next;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign irq_req = req_reg;
  assign irq_vector = vec_off_reg;
  assign irq_is_exc = exc_off_reg;
  assign ctx_push_bytes = `IPWU_CTX_BYTES;
  assign ctx_save_psw = 1'b1;
  assign src_pending = pend_reg;
  assign exc_pending = exc_pend_reg;
  assign level_active = lvl_act_reg;
  assign exc_active = exc_act_reg;
  assign stby_halt = (stby_reg == ipwu_pkg::IPWU_HALT);
  assign stby_hold = (stby_reg == ipwu_pkg::IPWU_HOLD);
  assign stby_low_speed_hold = (stby_reg == ipwu_pkg::IPWU_LOW_SPEED_HOLD_STANDBY);

endmodule // ipwu_top

`default_nettype wire

//--- tb/ipwu_checker.sv
// Port-level assertions of the interrupt priority and wake unit
`timescale 1ns/100ps
`default_nettype none

module ipwu_checker (
  input wire logic clock, // Clock
  input wire logic resetn, // Reset, low
  input wire logic [58:0] src_clear, // Pending clears
  input wire logic reset_pin_low, // Reset pin
  input wire logic [7:0] ext_pin_level_hit, // Pin levels
  input wire logic wdt_expire, // Expiry
  input wire logic wdt_reset_mode, // Expiry mode
  input wire logic irq_ack, // Core ack
  input wire logic irq_req, // Offer
  input wire logic [19:0] irq_vector, // Offered address
  input wire logic irq_is_exc, // Exception offer
  input wire logic ctx_push, // Push pulse
  input wire logic [2:0] ctx_push_bytes, // Push size
  input wire logic ctx_save_psw, // Status saved
  input wire logic wdt_reset, // Reset pulse
  input wire logic [58:0] src_pending, // Pending flags
  input wire logic [2:0] level_active, // Levels in service
  input wire logic exc_active, // Exception running
  input wire logic stby_halt, // Halt
  input wire logic stby_hold, // Full hold
  input wire logic stby_low_speed_hold // Low-speed hold
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  // ------------------------------------------------------------
  // Acceptance and vectors
  // ------------------------------------------------------------
  a_ctx_push_ack: assert property (irq_req && irq_ack |=> ctx_push && ctx_push_bytes == 3'h6 && ctx_save_psw)
    else $error("no six-byte push after ack");
  a_ctx_push_only: assert property (ctx_push |-> $past(irq_ack) && $past(irq_req))
    else $error("push without ack");
  a_exc_vector: assert property (irq_req && irq_is_exc |-> irq_vector == 20'h08080)
    else $error("bad exception vector");
  a_per_vector: assert property (irq_req && !irq_is_exc |-> irq_vector[19:6] == 14'h0200 && irq_vector[1:0] == 2'h0
    && irq_vector[5:2] != 4'h4 && irq_vector[5:2] != 4'ha)
    else $error("bad peripheral vector");
  a_exc_excludes: assert property (exc_active |-> !irq_req)
    else $error("offer during exception");
  a_top_blocks: assert property (level_active[2] |-> !irq_req || irq_is_exc)
    else $error("offer above top level");
  a_ack_service: assert property (irq_req && irq_ack |=> exc_active || level_active != 3'h0)
    else $error("ack not in service");
  a_wdt_reset: assert property (wdt_reset == ($past(wdt_expire) && $past(wdt_reset_mode)))
    else $error("watchdog reset mismatch");
  a_pending_held: assert property ((($past(src_pending) & ~$past(src_clear)) & ~src_pending) == 59'h0)
    else $error("pending lost");

  // ------------------------------------------------------------
  // Standby release
  // ------------------------------------------------------------
  a_halt_wake: assert property (stby_halt && reset_pin_low |=> !stby_halt)
    else $error("halt not released");
  a_hold_wake: assert property (stby_hold && (reset_pin_low || ext_pin_level_hit != 8'h0) |=> !stby_hold)
    else $error("hold not released");
  a_lsh_timer: assert property (stby_low_speed_hold && src_pending[2:1] != 2'h0 |=> !stby_low_speed_hold)
    else $error("low-speed hold not released");
endmodule // ipwu_checker

`default_nettype wire

//--- tb/ipwu_core_model.sv
// Processor core model that takes offered vectors
`timescale 1ns/100ps
`default_nettype none

module ipwu_core_model (
  input wire logic clock, // Clock
  input wire logic resetn, // Reset, low
  input wire logic irq_req, // Offer
  input wire logic [19:0] irq_vector, // Offered address
  input wire logic irq_is_exc, // Exception offer
  input wire logic core_en, // Takes offers
  input wire logic [3:0] core_delay, // Cycles before ack
  output logic irq_ack, // Ack pulse
  output logic [19:0] taken_vec, // Last taken address
  output logic taken_exc, // Last taken kind
  output logic [15:0] n_taken // Taken count
);
  logic [3:0] wait_reg;

  // Ack after the delay, held until the sampling edge, then capture
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_ack <= 1'b0;
      wait_reg <= 4'h0;
      taken_vec <= 20'h0;
      taken_exc <= 1'b0;
      n_taken <= 16'h0;
    end
    else
    begin
      irq_ack <= 1'b0;
      wait_reg <= 4'h0;
      if (irq_ack && irq_req)
      begin
        taken_vec <= irq_vector;
        taken_exc <= irq_is_exc;
        n_taken <= n_taken + 16'h1;
      end
      else if (core_en && irq_req && !irq_ack)
      begin
        if (wait_reg >= core_delay)
          irq_ack <= 1'b1;
        else
          wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule // ipwu_core_model

`default_nettype wire

//--- tb/interrupt_priority_wake_unit_tb.sv
// Self-checking bench of the interrupt priority and wake unit
`timescale 1ns/100ps
`default_nettype none

module interrupt_priority_wake_unit_tb;
  logic clock, resetn, global_irq_en, wdt_expire, wdt_reset_mode, irq_ack, irq_return, reset_pin_low;
  logic halt_enter, hold_enter, low_speed_hold_standby_enter, core_en, taken_exc;
  logic irq_req, irq_is_exc, ctx_push, ctx_save_psw, wdt_reset, exc_active;
  logic stby_halt, stby_hold, stby_low_speed_hold;
  logic [58:0] src_req, src_enable, src_clear, src_pending;
  logic [31:0] vec_level;
  logic [4:0] exc_req, exc_clear, exc_pending;
  logic [7:0] exception_enable_low, exception_enable_high, ext_pin_level_hit;
  logic [19:0] irq_vector, taken_vec;
  logic [2:0] ctx_push_bytes, level_active;
  logic [3:0] core_delay;
  logic [15:0] n_taken, n0;
  int n_mismatch, checked, s;
  int first[14] = '{0, 1, 3, 5, 6, 7, 14, 21, 24, 28, 31, 33, 39, 47};
  int slot_of[14] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 11, 12, 13, 14, 15};
  int wk[9] = '{10, 26, 35, 41, 43, 47, 50, 1, 1};

  ipwu_top i_ipwu_top (.*);
  ipwu_core_model i_ipwu_core_model (.*);

  // Clock, 25 ns period
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic pulse(input logic [58:0] m, input logic [4:0] x);
    @(posedge clock);
    src_req <= m;
    exc_req <= x;
    @(posedge clock);
    src_req <= 59'h0;
    exc_req <= 5'h0;
  endtask

  task automatic take(input logic [19:0] v, input logic x);
    int k;
    k = 0;
    while (n_taken === n0 && k < 80)
    begin
      @(negedge clock);
      k++;
    end
    if (k >= 80)
    begin
      n_mismatch++;
      give_verdict();
    end
    else
    begin
      n0 = n_taken;
      check("vector", taken_vec, v);
      check("exception", taken_exc, x);
    end
  endtask

  task automatic serve(input logic [58:0] m, input logic [4:0] x, input logic r);
    @(posedge clock);
    src_clear <= m;
    exc_clear <= x;
    irq_return <= r;
    @(posedge clock);
    src_clear <= 59'h0;
    exc_clear <= 5'h0;
    irq_return <= 1'b0;
  endtask

  task automatic enter(input logic h, input logic l);
    @(posedge clock);
    hold_enter <= h;
    low_speed_hold_standby_enter <= l;
    halt_enter <= !h && !l;
    @(posedge clock);
    {hold_enter, low_speed_hold_standby_enter, halt_enter} <= 3'h0;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {resetn, global_irq_en, wdt_expire, wdt_reset_mode, irq_return, reset_pin_low} = 6'h10;
    {halt_enter, hold_enter, low_speed_hold_standby_enter, core_en} = 4'h1;
    {src_req, src_clear, exc_req, exc_clear, vec_level, ext_pin_level_hit} = '0;
    src_enable = '1;
    exception_enable_low = 8'h1f;
    exception_enable_high = 8'h01;
    core_delay = 4'h0;
    n0 = 16'h0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    check("push bytes", ctx_push_bytes, 3'h6);
    check("status saved", ctx_save_psw, 1'b1);
    // Every source lands on its slot
    for (int i = 0; i < 59; i++)
    begin
      for (int j = 0; j < 14; j++)
        if (i >= first[j])
          s = slot_of[j];
      pulse(59'h1 << i, 5'h0);
      take(20'h08000 + 20'(4 * s), 1'b0);
      serve(59'h1 << i, 5'h0, 1'b1);
    end
    $display("test vector map done");
    // Higher level first, then same level by address
    vec_level <= 32'h02001000;
    pulse((59'h1 << 7) | (59'h1 << 31), 5'h0);
    take(20'h08030, 1'b0);
    serve(59'h1 << 31, 5'h0, 1'b1);
    take(20'h08018, 1'b0);
    serve(59'h1 << 7, 5'h0, 1'b1);
    vec_level <= 32'h01001000;
    pulse((59'h1 << 7) | (59'h1 << 31), 5'h0);
    take(20'h08018, 1'b0);
    serve(59'h1 << 7, 5'h0, 1'b1);
    take(20'h08030, 1'b0);
    serve(59'h1 << 31, 5'h0, 1'b1);
    $display("test priority done");
    // Nesting with a slow core, equal level refused
    core_delay <= 4'h5;
    vec_level <= 32'h01000040;
    pulse(59'h1 << 7, 5'h0);
    take(20'h08018, 1'b0);
    pulse(59'h1 << 31, 5'h0);
    take(20'h08030, 1'b0);
    check("levels", level_active, 3'h3);
    pulse(59'h1 << 5, 5'h0);
    repeat (12) @(negedge clock);
    check("refused", n_taken, n0);
    check("kept", src_pending[5], 1'b1);
    serve(59'h1 << 31, 5'h0, 1'b1);
    take(20'h0800c, 1'b0);
    serve(59'h1 << 5, 5'h0, 1'b1);
    serve(59'h1 << 7, 5'h0, 1'b1);
    core_delay <= 4'h0;
    $display("test nesting done");
    // Exception ignores the global flag and holds off the peripheral until it returns
    global_irq_en <= 1'b0;
    pulse(59'h1 << 5, 5'h04);
    take(20'h08080, 1'b1);
    global_irq_en <= 1'b1;
    repeat (10) @(negedge clock);
    check("blocked", n_taken, n0);
    serve(59'h0, 5'h04, 1'b1);
    take(20'h0800c, 1'b0);
    serve(59'h1 << 5, 5'h0, 1'b1);
    exception_enable_high <= 8'h00;
    pulse(59'h0, 5'h01);
    repeat (8) @(negedge clock);
    check("class off", n_taken, n0);
    check("exc kept", exc_pending[0], 1'b1);
    exception_enable_high <= 8'h01;
    take(20'h08080, 1'b1);
    serve(59'h0, 5'h01, 1'b1);
    $display("test exception done");
    // Watchdog as interrupt, then as reset
    pulse(59'h0, 5'h0);
    wdt_expire <= 1'b1;
    @(posedge clock);
    wdt_expire <= 1'b0;
    take(20'h08000, 1'b0);
    serve(59'h1, 5'h0, 1'b1);
    wdt_reset_mode <= 1'b1;
    wdt_expire <= 1'b1;
    @(posedge clock);
    wdt_expire <= 1'b0;
    @(negedge clock);
    check("wdt reset", wdt_reset, 1'b1);
    check("no wdt irq", src_pending[0], 1'b0);
    $display("test watchdog done");
    // Halt ends on a grantable request
    core_en <= 1'b0;
    enter(1'b0, 1'b0);
    pulse(59'h1 << 5, 5'h0);
    repeat (3) @(negedge clock);
    check("halt left", stby_halt, 1'b0);
    serve(59'h1 << 5, 5'h0, 1'b0);
    // Hold and low-speed hold wake causes
    src_enable <= 59'h0;
    enter(1'b1, 1'b0);
    ext_pin_level_hit <= 8'h08;
    @(posedge clock);
    ext_pin_level_hit <= 8'h00;
    repeat (2) @(negedge clock);
    check("pin wake", stby_hold, 1'b0);
    for (int e = 0; e < 9; e++)
    begin
      enter(e < 8, e == 8);
      pulse(59'h1 << wk[e], 5'h0);
      repeat (3) @(negedge clock);
      check("asleep", stby_hold | stby_low_speed_hold, e == 7);
      reset_pin_low <= 1'b1;
      @(posedge clock);
      reset_pin_low <= 1'b0;
      @(negedge clock);
      check("reset pin wake", stby_hold, 1'b0);
      serve(59'h1 << wk[e], 5'h0, 1'b0);
    end
    $display("test standby done");
    give_verdict();
  end
endmodule // interrupt_priority_wake_unit_tb

bind ipwu_top ipwu_checker i_ipwu_checker (.*);

`default_nettype wire
